// [core/ebp_bus_port.v]
// External bus port: port 0/2 multiplexing and bus cycle sequencing
// How it works
// R1 - Each external bus cycle loads all ones into low port latch.
// R2 - Bus cycle never alters high port latch contents.
// R3 - Nonpage idle: port 0 floats, port 2 shows its latch.
// R4 - Nonpage: AD on port 0, high address or latch on port 2.
// R5 - Page mode: port 2 muxes high address and data; port 0 low address.
// R6 - Page 8-bit access: latch on port 2 when data absent.
// R7 - Page idle: both ports high impedance.
// R8 - Select 00: 18-bit bus, separate read and program strobes.
// R9 - Select 01: program strobe for all reads, read pin is A16.
// R10 - Select 10: 16-bit bus, read pin general I/O, all folded.
// R11 - Select 11: read strobe below 80:0000H, program strobe above.
// R12 - Region 01 uses its own wait count; others share one.
// R13 - Region 00 up to 041FH stays on chip; above goes external.
// R14 - Regions 00 and 01 at same offset give same port 0/2 pins.
// R15 - Drivers off during read data phase.
`timescale 1ns/100ps
`default_nettype none
`include "ebp_consts.vh"

module ebp_bus_port (
  input  wire        mclk,                 // CPU clock
  input  wire        nrst,                 // Sync reset, active low
  input  wire        page_mode,            // Page mode selected
  input  wire [1:0]  strobe_region_select, // Strobe/width configuration
  input  wire [1:0]  wait_region01,        // Wait states for region 01:
  input  wire [1:0]  wait_common,          // Wait states for other regions
  input  wire        req,                  // Access request
  input  wire [23:0] req_addr,             // Internal address
  input  wire        req_write,            // Write access
  input  wire        req_code,             // Code fetch
  input  wire        req_short,            // 8-bit address access
  input  wire [7:0]  req_wdata,            // Write data
  output wire        req_ready,            // Request accepted this cycle
  output reg         done,                 // Access complete pulse
  output reg         done_on_chip,         // Completed access was on chip
  output reg  [7:0]  rdata,                // Read data
  input  wire        low_latch_we,         // Software write to low latch
  input  wire [7:0]  low_latch_wdata,      // Data for low latch
  input  wire        high_latch_we,        // Software write to high latch
  input  wire [7:0]  high_latch_wdata,     // Data for high latch
  output reg  [7:0]  low_port_latch,       // Low port latch contents
  output reg  [7:0]  high_port_latch,      // High port latch contents
  input  wire [7:0]  p0_in,                // Port 0 pin input
  output reg  [7:0]  p0_out,               // Port 0 pin output
  output reg         p0_oe,                // Port 0 output enable
  input  wire [7:0]  p2_in,                // Port 2 pin input
  output reg  [7:0]  p2_out,               // Port 2 pin output
  output reg         p2_oe,                // Port 2 output enable
  output reg         ale,                  // Address latch enable
  output reg         read_strobe_n,        // Data read strobe
  output reg         write_strobe_n,       // Write strobe
  output reg         program_store_strobe_n, // Program store strobe
  output reg         address_bit_sixteen,  // Address bit 16 during bus cycle
  output reg         address_bit_seventeen, // A17
  output reg         port_three_bit_seven_oe, // Block owns read pin
  output reg         port_three_bit_seven  // Read pin level from block
);

  reg  [2:0]  phase;
  reg  [1:0]  wcnt;
  reg  [17:0] cur_addr;
  reg         cur_write;
  reg         cur_short;
  reg         cur_program_store_strobe_n;
  reg         cur_rd;
  reg         cur_a16pin;
  reg         cur_gpio;
  reg  [7:0]  cur_wdata;

  wire        map_on_chip;
  wire [17:0] map_addr;
  wire        map_program_store_strobe_n;
  wire        map_rd;
  wire        map_a16;
  wire        map_gpio;
  wire [1:0]  map_wait;

  ebp_strobe_map u_map (
    .strobe_region_select (strobe_region_select),
    .int_addr             (req_addr),
    .is_code              (req_code),
    .is_write             (req_write),
    .wait_region01        (wait_region01),
    .wait_common          (wait_common),
    .on_chip              (map_on_chip),
    .ext_addr             (map_addr),
    .use_program_store_strobe_n             (map_program_store_strobe_n),
    .use_rd               (map_rd),
    .a16_on_rd_pin        (map_a16),
    .rd_pin_gpio          (map_gpio),
    .wait_count           (map_wait)
  );

  assign req_ready = (phase == `EBP_PH_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @(posedge mclk) begin
    if (!nrst) begin
      phase      <= `EBP_PH_IDLE;
      wcnt       <= 2'h0;
      cur_addr   <= 18'h00000;
      cur_write  <= 1'b0;
      cur_short  <= 1'b0;
      cur_program_store_strobe_n   <= 1'b0;
      cur_rd     <= 1'b0;
      cur_a16pin <= 1'b0;
      cur_gpio   <= 1'b0;
      cur_wdata  <= 8'h00;
      done       <= 1'b0;
      done_on_chip <= 1'b0;
      rdata      <= 8'h00;
    end else begin
      done         <= 1'b0;
      done_on_chip <= 1'b0;
      case (phase)
        `EBP_PH_IDLE: begin
          if (req) begin
            // R13 on-chip completes at once
            if (map_on_chip) begin
              done         <= 1'b1;
              done_on_chip <= 1'b1;
            end else begin
              phase      <= `EBP_PH_ADDR;
              cur_addr   <= map_addr;
              cur_write  <= req_write;
              cur_short  <= req_short;
              cur_program_store_strobe_n   <= map_program_store_strobe_n;
              cur_rd     <= map_rd;
              cur_a16pin <= map_a16;
              cur_gpio   <= map_gpio;
              cur_wdata  <= req_wdata;
              wcnt       <= map_wait;
            end
          end
        end
        `EBP_PH_ADDR: phase <= `EBP_PH_DATA;
        `EBP_PH_DATA: begin
          if (wcnt != 2'h0) begin
            wcnt  <= wcnt - 2'h1;
          end else begin
            phase <= `EBP_PH_DONE;
          end
        end
        `EBP_PH_DONE: begin
          phase <= `EBP_PH_IDLE;
          done  <= 1'b1;
          // Strobe pins lag the phase by one clock, so read data is valid here with any wait count
          if (!cur_write) begin
            rdata <= page_mode ? p2_in : p0_in;
          end
        end
        default: phase <= `EBP_PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port latches
  always @(posedge mclk) begin
    if (!nrst) begin
      low_port_latch  <= `EBP_LATCH_ALL_ONES;
      high_port_latch <= `EBP_LATCH_ALL_ONES;
    end else begin
      // R1 bus cycle loads FFH
      if (phase == `EBP_PH_ADDR) begin
        low_port_latch <= `EBP_LATCH_ALL_ONES;
      end else if (low_latch_we) begin
        low_port_latch <= low_latch_wdata;
      end
      // R2 only software writes
      if (high_latch_we) begin
        high_port_latch <= high_latch_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered
  wire busy    = (phase != `EBP_PH_IDLE);
  wire in_addr = (phase == `EBP_PH_ADDR);
  wire in_data = (phase == `EBP_PH_DATA);
  wire in_done = (phase == `EBP_PH_DONE);

  always @(posedge mclk) begin
    if (!nrst) begin
      p0_out <= 8'h00;
      p0_oe  <= 1'b0;
      p2_out <= 8'h00;
      p2_oe  <= 1'b0;
      ale    <= 1'b0;
      read_strobe_n          <= 1'b1;
      write_strobe_n         <= 1'b1;
      program_store_strobe_n <= 1'b1;
      address_bit_sixteen    <= 1'b0;
      address_bit_seventeen  <= 1'b0;
      port_three_bit_seven_oe <= 1'b0;
      port_three_bit_seven   <= 1'b1;
    end else begin
      ale    <= in_addr;
      read_strobe_n  <= !(in_data && cur_rd);
      write_strobe_n <= !(in_data && cur_write);
      program_store_strobe_n <= !(in_data && cur_program_store_strobe_n);
      address_bit_seventeen  <= busy ? cur_addr[17] : 1'b0;
      address_bit_sixteen    <= busy ? cur_addr[16] : 1'b0;
      // R9 read pin as A16
      // R10 read pin released
      port_three_bit_seven_oe <= !cur_gpio;
      port_three_bit_seven <= cur_a16pin ? cur_addr[16] : !(in_data && cur_rd);
      if (!busy) begin
        // R3 nonpage idle
        // R7 page idle
        p0_oe  <= 1'b0;
        p0_out <= 8'h00;
        p2_oe  <= !page_mode;
        p2_out <= page_mode ? 8'h00 : high_port_latch;
      end else if (!page_mode) begin
        // R4 nonpage address/data
        p2_oe  <= 1'b1;
        p2_out <= cur_short ? high_port_latch : cur_addr[15:8];
        if (in_addr) begin
          p0_oe  <= 1'b1;
          p0_out <= cur_addr[7:0];
        end else begin
          // R15 release for read data
          p0_oe  <= cur_write;
          p0_out <= cur_wdata;
        end
      end else begin
        // R5 page mode mux on port 2
        p0_oe  <= 1'b1;
        p0_out <= cur_addr[7:0];
        if (in_addr || in_done) begin
          p2_oe  <= 1'b1;
          // R6 latch when no data
          p2_out <= cur_short ? high_port_latch : cur_addr[15:8];
        end else begin
          // R15 release for read data
          p2_oe  <= cur_write;
          p2_out <= cur_wdata;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [core/ebp_consts.vh]
// Constants for the external bus port and strobe map block
`ifndef EBP_CONSTS_VH
`define EBP_CONSTS_VH

`define EBP_LATCH_ALL_ONES   8'hFF
`define EBP_RSEL_SPLIT       2'h0
`define EBP_RSEL_ALL_PROGRAM_STORE_STROBE_N    2'h1
`define EBP_RSEL_FOLD16      2'h2
`define EBP_RSEL_HALF        2'h3
`define EBP_ONCHIP_RAM_TOP   24'h00041F
`define EBP_REGION_00        8'h00
`define EBP_REGION_01        8'h01
`define EBP_PROGRAM_STORE_STROBE_N_REGION_BIT  23
`define EBP_WAIT_W           2
`define EBP_PH_IDLE          3'h0
`define EBP_PH_ADDR          3'h1
`define EBP_PH_DATA          3'h2
`define EBP_PH_WAIT          3'h3
`define EBP_PH_DONE          3'h4

`endif

// [core/ebp_strobe_map.v]
// Strobe decode and internal-to-external address mapping
`timescale 1ns/100ps
`default_nettype none
`include "ebp_consts.vh"

module ebp_strobe_map (
  input  wire [1:0]  strobe_region_select, // Strobe/width configuration
  input  wire [23:0] int_addr,             // Internal 24-bit address
  input  wire        is_code,              // Access is a code fetch
  input  wire        is_write,             // Access is a write
  input  wire [1:0]  wait_region01,        // Wait count for region 01:
  input  wire [1:0]  wait_common,          // Wait count for other regions
  output reg         on_chip,              // Access stays on chip
  output reg  [17:0] ext_addr,             // External address
  output reg         use_program_store_strobe_n,             // Read goes out on program strobe
  output reg         use_rd,               // Read goes out on read strobe
  output reg         a16_on_rd_pin,        // Read pin carries address bit 16
  output reg         rd_pin_gpio,          // Read pin free for general I/O
  output reg  [1:0]  wait_count            // Wait states for this access
);

  always @* begin
    // R13 on-chip RAM up to 041FH
    on_chip  = (int_addr[23:16] == `EBP_REGION_00) &&
               (int_addr <= `EBP_ONCHIP_RAM_TOP);
    // R14 same low 16 bits
    ext_addr = {int_addr[17:16], int_addr[15:0]};
    use_program_store_strobe_n      = 1'b0;
    use_rd        = 1'b0;
    a16_on_rd_pin = 1'b0;
    rd_pin_gpio   = 1'b0;
    case (strobe_region_select)
      // R8 18-bit, split strobes
      `EBP_RSEL_SPLIT: begin
        use_program_store_strobe_n = !is_write && is_code;
        use_rd   = !is_write && !is_code;
      end
      // R9 program strobe, A16 on rd
      `EBP_RSEL_ALL_PROGRAM_STORE_STROBE_N: begin
        ext_addr[17]  = 1'b0;
        use_program_store_strobe_n      = !is_write;
        a16_on_rd_pin = 1'b1;
      end
      // R10 fold into 64K
      `EBP_RSEL_FOLD16: begin
        ext_addr[17:16] = 2'h0;
        use_program_store_strobe_n        = !is_write;
        rd_pin_gpio     = 1'b1;
      end
      // R11 split at 80:0000
      default: begin
        ext_addr[17:16] = 2'h0;
        use_program_store_strobe_n = !is_write && int_addr[`EBP_PROGRAM_STORE_STROBE_N_REGION_BIT];
        use_rd   = !is_write && !int_addr[`EBP_PROGRAM_STORE_STROBE_N_REGION_BIT];
      end
    endcase
    // R12 independent region 01 waits
    wait_count = (int_addr[23:16] == `EBP_REGION_01) ? wait_region01 : wait_common;
  end

endmodule
`default_nettype wire

// [tb/ebp_bus_monitor.sv]
// Assertion checker for the external bus port
`timescale 1ns/100ps
`default_nettype none
module ebp_bus_monitor (
  input wire        mclk,                   // Clock
  input wire        nrst,                   // Reset
  input wire        page_mode,              // Page mode
  input wire [1:0]  strobe_region_select,   // Strobe config
  input wire        req,                    // Request
  input wire        req_ready,              // Idle
  input wire [23:0] req_addr,               // Address
  input wire        req_short,              // 8-bit access
  input wire        done,                   // Complete
  input wire        done_on_chip,           // On chip
  input wire [7:0]  low_port_latch,         // Low latch
  input wire [7:0]  high_port_latch,        // High latch
  input wire [7:0]  p0_out,                 // Port 0 out
  input wire        p0_oe,                  // Port 0 enable
  input wire [7:0]  p2_out,                 // Port 2 out
  input wire        p2_oe,                  // Port 2 enable
  input wire        ale,                    // Address latch
  input wire        read_strobe_n,          // Read strobe
  input wire        program_store_strobe_n  // Program strobe
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);
  low_latch_a:
    assert property (ale |=> low_port_latch == 8'hFF) else $error("Low latch not ones");
  high_latch_a:
    assert property (ale |=> $stable(high_port_latch)) else $error("High latch changed");
  nonpage_idle_a:
    assert property ((req_ready && !page_mode && $stable(high_port_latch))[*3]
      |-> !p0_oe && p2_oe && p2_out == high_port_latch) else $error("Nonpage idle pins");
  page_idle_a:
    assert property ((req_ready && page_mode)[*3] |-> !p0_oe && !p2_oe)
      else $error("Page idle pins driven");
  low_addr_a:
    assert property (ale |-> p0_oe && p0_out == $past(req_addr[7:0], 2))
      else $error("Port 0 low address");
  high_addr_a:
    assert property (ale && !$past(req_short, 2) |-> p2_oe && p2_out == $past(req_addr[15:8], 2))
      else $error("Port 2 high address");
  short_page_a:
    assert property (ale && $past(req_short, 2) |-> p2_oe && p2_out == high_port_latch)
      else $error("Port 2 latch page");
  read_float_a:
    assert property (!read_strobe_n || !program_store_strobe_n |-> (page_mode ? !p2_oe : !p0_oe))
      else $error("Driver on in read");
  on_chip_a:
    assert property (req && req_ready && req_addr <= 24'h00041F |=> done && done_on_chip)
      else $error("On chip access late");
  ext_done_a:
    assert property (req && req_ready && req_addr > 24'h00041F
      |=> (!done)[*3] ##[1:5] done && !done_on_chip) else $error("External access timing");
  no_read_a:
    assert property (strobe_region_select == 2'h1 || strobe_region_select == 2'h2
      |-> read_strobe_n) else $error("Read strobe used");
endmodule
`default_nettype wire

// [tb/ebp_bus_port_bench.sv]
// Testbench for the external bus port
`timescale 1ns/100ps
`default_nettype none
module ebp_bus_port_bench;
  logic        mclk, nrst, page_mode, req, req_write, req_code, req_short, srd, sps, a16;
  logic        low_latch_we, high_latch_we, req_ready, done, done_on_chip, p0_oe, p2_oe;
  logic        ale, read_strobe_n, write_strobe_n, program_store_strobe_n;
  logic        address_bit_sixteen, address_bit_seventeen;
  logic        port_three_bit_seven_oe, port_three_bit_seven;
  logic        a17, p37, swr;
  logic [7:0]  wd;
  logic [1:0]  strobe_region_select, wait_region01, wait_common;
  logic [23:0] req_addr;
  logic [7:0]  req_wdata, rdata, low_latch_wdata, high_latch_wdata, low_port_latch;
  logic [7:0]  high_port_latch, p0_in, p0_out, p2_in, p2_out, p0a, p2a;
  integer      n_errors, check_count, ncyc, k0, i;
  logic [1:0]  tsel [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [23:0] tadr [6] = '{24'h020500, 24'h000500, 24'h010500, 24'h010500, 24'h7FFFFF,
                            24'h800000};
  logic        tcod [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic [7:0]  texp [6] = '{8'h02, 8'h01, 8'h01, 8'h01, 8'h02, 8'h01};
  ebp_bus_port uut (.mclk, .nrst, .page_mode, .strobe_region_select, .wait_region01,
    .wait_common, .req, .req_addr, .req_write, .req_code, .req_short, .req_wdata,
    .req_ready, .done, .done_on_chip, .rdata, .low_latch_we, .low_latch_wdata,
    .high_latch_we, .high_latch_wdata, .low_port_latch, .high_port_latch, .p0_in,
    .p0_out, .p0_oe, .p2_in, .p2_out, .p2_oe, .ale, .read_strobe_n, .write_strobe_n,
    .program_store_strobe_n, .address_bit_sixteen, .address_bit_seventeen,
    .port_three_bit_seven_oe, .port_three_bit_seven);
  ebp_mem_model mem (.mclk, .page_mode, .ale, .p0_out, .p0_oe, .p2_out, .p2_oe,
    .read_strobe_n, .program_store_strobe_n, .p0_in, .p2_in);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count = check_count + 1;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors = n_errors + 1;
    end
  endtask
  task acc(input logic [1:0] sel, input logic [23:0] a, input logic w, c, s);
    @(posedge mclk);
    strobe_region_select <= sel;
    req <= 1'b1;
    req_addr <= a;
    req_write <= w;
    req_code <= c;
    req_short <= s;
    @(posedge mclk);
    req <= 1'b0;
    #1;
    srd = 1'b0;
    sps = 1'b0;
    swr = 1'b0;
    wd = 8'h00;
    ncyc = 0;
    while (done !== 1'b1 && ncyc < 20) begin
      @(posedge mclk);
      #1;
      ncyc = ncyc + 1;
      if (ale) begin
        p0a = p0_out;
        p2a = p2_out;
        a16 = address_bit_sixteen;
        a17 = address_bit_seventeen;
        p37 = port_three_bit_seven;
      end
      if (!read_strobe_n) srd = 1'b1;
      if (!program_store_strobe_n) sps = 1'b1;
      if (!write_strobe_n) begin
        swr = 1'b1;
        wd = page_mode ? p2_out : p0_out;
      end
    end
    chk("done", 8'h01, {7'h0, done});
  endtask
  task setl(input logic hi, input logic [7:0] d);
    @(posedge mclk);
    low_latch_we <= !hi;
    high_latch_we <= hi;
    low_latch_wdata <= d;
    high_latch_wdata <= d;
    @(posedge mclk);
    low_latch_we <= 1'b0;
    high_latch_we <= 1'b0;
  endtask
  task complete_run;
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #4000;
    n_errors = n_errors + 1;
    complete_run;
  end
  initial begin
    {nrst, page_mode, req, req_write, req_code, req_short, low_latch_we, high_latch_we} = 0;
    {strobe_region_select, wait_common, req_addr, req_wdata} = 0;
    {low_latch_wdata, high_latch_wdata} = 0;
    req_wdata = 8'hC3;
    wait_region01 = 2'h3;
    n_errors = 0;
    check_count = 0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    acc(2'h0, 24'h00041F, 1'b0, 1'b0, 1'b0);
    chk("on_chip", 8'h01, {7'h0, done_on_chip});
    setl(1'b0, 8'hAA);
    setl(1'b1, 8'h3C);
    acc(2'h0, 24'h000420, 1'b0, 1'b0, 1'b0);
    k0 = ncyc;
    chk("low_latch", 8'hFF, low_port_latch);
    chk("addr_lo", 8'h20, p0a);
    chk("addr_hi", 8'h04, p2a);
    chk("rdata", 8'h85, rdata);
    acc(2'h0, 24'h010420, 1'b0, 1'b0, 1'b0);
    chk("alias_lo", 8'h20, p0a);
    chk("alias_hi", 8'h04, p2a);
    chk("waits", 8'h03, 8'(ncyc - k0));
    acc(2'h0, 24'h000480, 1'b1, 1'b0, 1'b1);
    chk("short_page", 8'h3C, p2a);
    chk("wr_strobe", 8'h01, {6'h0, srd, swr});
    chk("wr_data", 8'hC3, wd);
    chk("high_latch", 8'h3C, high_port_latch);
    for (i = 0; i < 6; i = i + 1) begin
      acc(tsel[i], tadr[i], 1'b0, tcod[i], 1'b0);
      chk("strobes", texp[i], {6'h0, srd, sps});
      chk("rdata", tadr[i][7:0] ^ 8'hA5, rdata);
      if (i == 2) chk("a16", 8'h01, {7'h0, a16});
      if (i == 3) chk("gpio", 8'h00, {7'h0, port_three_bit_seven_oe});
      chk("a17", {7'h0, i == 0}, {7'h0, a17});
      if (i == 2) chk("rd_pin_a16", 8'h01, {7'h0, p37});
      if (i == 3) chk("fold_a16", 8'h00, {7'h0, a16});
    end
    @(posedge mclk);
    page_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    acc(2'h0, 24'h000455, 1'b0, 1'b0, 1'b0);
    chk("page_rdata", 8'hF0, rdata);
    acc(2'h0, 24'h000456, 1'b1, 1'b0, 1'b0);
    chk("page_wr", 8'h01, {7'h0, swr});
    chk("page_wdata", 8'hC3, wd);
    acc(2'h0, 24'h000470, 1'b0, 1'b0, 1'b1);
    chk("page_short", 8'h3C, p2a);
    repeat (4) @(posedge mclk);
    complete_run;
  end
endmodule
bind ebp_bus_port ebp_bus_monitor mon (.mclk, .nrst, .page_mode, .strobe_region_select,
  .req, .req_ready, .req_addr, .req_short, .done, .done_on_chip, .low_port_latch,
  .high_port_latch, .p0_out, .p0_oe, .p2_out, .p2_oe, .ale, .read_strobe_n,
  .program_store_strobe_n);
`default_nettype wire

// [tb/ebp_mem_model.sv]
// Behavioural external memory on ports 0 and 2
`timescale 1ns/100ps
`default_nettype none
module ebp_mem_model (
  input  wire        mclk,                   // Clock
  input  wire        page_mode,              // Page mode
  input  wire        ale,                    // Address latch
  input  wire [7:0]  p0_out,                 // Port 0 out
  input  wire        p0_oe,                  // Port 0 enable
  input  wire [7:0]  p2_out,                 // Port 2 out
  input  wire        p2_oe,                  // Port 2 enable
  input  wire        read_strobe_n,          // Read strobe
  input  wire        program_store_strobe_n, // Program strobe
  output logic [7:0] p0_in,                  // Port 0 level
  output logic [7:0] p2_in                   // Port 2 level
);
  logic [7:0] lo;
  logic [7:0] junk = 8'h5A;
  logic       rd;
  always @(posedge mclk) begin
    junk <= junk + 8'h3B;
    if (ale) begin
      lo <= p0_out;
    end
  end
  assign rd = !read_strobe_n || !program_store_strobe_n;
  assign p0_in = p0_oe ? p0_out : (rd && !page_mode) ? lo ^ 8'hA5 : junk;
  assign p2_in = p2_oe ? p2_out : (rd && page_mode) ? lo ^ 8'hA5 : 8'hFF;
endmodule
`default_nettype wire
